// >>> bench/core_model.sv
// Purpose: Core model that fetches offered vectors and returns
// Assumes: Drives at the falling edge of the core clock
// Notes:   Automatic fetch waits i_delay cycles; manual fetch by task
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_take_valid,
    input  wire logic       i_auto,
    input  wire logic [3:0] i_delay,
    output logic            o_take_ack,
    output logic            o_exc_return,
    output logic [5:0]      o_ret_excnum
);
    // ****
    // Fetch and return
    // ****
    logic       auto_ack = 1'b0;
    logic       man_ack  = 1'b0;
    logic [3:0] wait_cnt = 4'h0;
    assign o_take_ack = auto_ack | man_ack;
    initial begin
        o_exc_return = 1'b0;
        o_ret_excnum = 6'h00;
    end
    // Holds each offer off for i_delay cycles, then fetches it
    always @(negedge i_clk_sys) begin
        auto_ack <= i_auto && i_take_valid && !auto_ack && wait_cnt == i_delay;
        wait_cnt <= (i_take_valid && !auto_ack && wait_cnt != i_delay) ? wait_cnt + 4'h1 : 4'h0;
    end
    task automatic ack_now();
        man_ack = 1'b1;
        @(negedge i_clk_sys);
        man_ack = 1'b0;
    endtask : ack_now
    task automatic ret_now(input logic [5:0] n);
        o_exc_return = 1'b1;
        o_ret_excnum = n;
        @(negedge i_clk_sys);
        o_exc_return = 1'b0;
        o_ret_excnum = ~n;
    endtask : ret_now
endmodule : core_model
`default_nettype wire

// >>> bench/irq_ctrl_props.sv
// Purpose: Concurrent checks on the interrupt controller ports
// Assumes: Bound to the controller top, one clock domain
// Notes:   Sees only ports of the controller
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props
    import irq_ctrl_pkg::*;
(
    input wire logic                  i_clk_sys,
    input wire logic                  i_rstn,
    input wire irq_ctrl_pkg::sw_cmd_t i_cmd,
    input wire logic                  i_take_ack,
    input wire logic                  i_exc_return,
    input wire logic                  o_take_valid,
    input wire logic [5:0]            o_take_excnum,
    input wire logic [31:0]           o_vector_addr,
    input wire logic [31:0]           o_enable,
    input wire logic [31:0]           o_pending,
    input wire logic [31:0]           o_active,
    input wire logic [2:0]            o_exec_rank
);
    // ****
    // Checks
    // ****
    wire logic [31:0] usable = ~RESERVED_MASK;
    wire logic        line_offer = o_take_valid && o_take_excnum >= EXC_IRQ_BASE;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    a_boot_first: assert property ($rose(i_rstn) |-> o_take_valid && !o_take_excnum)
        else $error("boot stack pointer offer missing");
    a_boot_order: assert property (
        o_take_valid && i_take_ack && o_take_excnum == EXC_NONE |=>
        o_take_valid && o_take_excnum == EXC_RESET)
        else $error("reset vector offer does not follow stack pointer");
    a_vector_addr: assert property (
        o_take_valid |-> o_vector_addr == (VECTOR_BASE | {24'h0, o_take_excnum, 2'b00}))
        else $error("vector address not four times exception number");
    a_enable_set: assert property (
        1'b1 |=> (o_enable & $past(i_cmd.set_enable) & usable)
        == ($past(i_cmd.set_enable) & usable))
        else $error("set enable lost");
    a_enable_clr: assert property (i_cmd.set_enable == 0 |=>
        (o_enable & $past(i_cmd.clr_enable)) == 0)
        else $error("clear enable lost");
    a_pend_set: assert property (!i_take_ack |=>
        (o_pending & $past(i_cmd.set_pending) & usable)
        == ($past(i_cmd.set_pending) & usable))
        else $error("set pending lost");
    a_no_disabled: assert property (
        line_offer |-> o_enable[o_take_excnum - EXC_IRQ_BASE])
        else $error("disabled line offered");
    a_ack_active: assert property (line_offer && i_take_ack |=>
        o_active[$past(o_take_excnum) - EXC_IRQ_BASE])
        else $error("accepted line not active");
    a_rank_block: assert property (line_offer |-> o_exec_rank > RANK_CFG_BASE)
        else $error("offer not more urgent than running handler");
    a_active_hold: assert property (!i_take_ack && !i_exc_return |=>
        $stable(o_active))
        else $error("active state changed without accept or return");
    a_reserved_off: assert property (
        ((o_enable | o_pending | o_active) & RESERVED_MASK) == 0)
        else $error("reserved line holds state");
    c_line_ack: cover property (line_offer && i_take_ack);
    c_preempt: cover property (line_offer && o_exec_rank != RANK_THREAD);
    c_return: cover property (i_exc_return);
endmodule : irq_ctrl_props
`default_nettype wire

// >>> bench/prioritized_vectored_irq_ctrl_bench.sv
// Purpose: Self-checking bench of the vectored interrupt controller
// Assumes: Inputs change at the falling edge
// Notes:   Boot fetches first, then source table, system, priority, fault and reset cases
`timescale 1ns/1ps
`default_nettype none
module prioritized_vectored_irq_ctrl_bench;
    import irq_ctrl_pkg::*;
    // ****
    // Bench
    // ****
    logic        i_clk_sys, i_rstn, i_nmi, i_hard_fault, auto_on;
    logic [77:0] src_v;
    logic [3:0]  auto_dly;
    sw_cmd_t     i_cmd, cmd_n;
    wire logic   i_take_ack, i_exc_return;
    wire logic [5:0] i_ret_excnum;
    logic        o_take_valid, o_wakeup;
    logic [5:0]  o_take_excnum;
    logic [2:0]  o_exec_rank, o_sys_pending, o_sys_active;
    logic [5:0]  o_sys_prio;
    logic [31:0] o_vector_addr, o_enable, o_pending, o_active, o_prio_rd_data;
    int          bad_count = 0, n_checks = 0, cycles = 0, k, ln;
    // Source bit, line, wake-capable
    int rows [23][3] = '{'{77,0,1}, '{76,1,1}, '{75,2,1}, '{74,3,1}, '{58,4,1},
        '{36,5,1}, '{33,6,0}, '{31,8,0}, '{30,9,0}, '{29,10,0}, '{28,11,0}, '{27,12,1},
        '{26,14,0}, '{18,16,1}, '{8,17,1}, '{7,18,1}, '{6,19,1}, '{5,20,0}, '{4,21,0},
        '{3,22,0}, '{2,23,0}, '{1,28,1}, '{0,29,0}};
    prioritized_vectored_irq_ctrl dut (
        .i_clk_sys, .i_rstn, .i_sources(src_v), .i_cmd, .i_nmi, .i_hard_fault,
        .i_take_ack, .i_exc_return, .i_ret_excnum, .o_take_valid, .o_take_excnum,
        .o_vector_addr, .o_enable, .o_pending, .o_active, .o_prio_rd_data,
        .o_sys_prio, .o_sys_pending, .o_sys_active, .o_exec_rank, .o_wakeup);
    core_model model (.i_clk_sys, .i_take_valid(o_take_valid), .i_auto(auto_on),
        .i_delay(auto_dly), .o_take_ack(i_take_ack), .o_exc_return(i_exc_return),
        .o_ret_excnum(i_ret_excnum));
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : tick
    task automatic go();
        i_cmd = cmd_n;
        tick(1);
        i_cmd = '0;
        cmd_n = '0;
        tick(1);
    endtask : go
    task automatic rd_prio(input logic [2:0] idx, input logic [31:0] exp);
        i_cmd.prio_rd_idx = idx;
        tick(2);
        chk("prio_rd", o_prio_rd_data, exp);
    endtask : rd_prio
    task automatic finish_test();
        $display("checks=%0d errors=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    initial begin
        {i_rstn, i_nmi, i_hard_fault, auto_on, src_v, i_cmd, cmd_n} = '0;
        auto_dly = 4'h2;
        tick(20);
        i_rstn = 1'b1;
        tick(1);
        chk("boot_exc", {o_take_valid, o_take_excnum, o_exec_rank}, 10'h207);
        for (k = 0; k < 8; k++) rd_prio(k[2:0], 32'h0);
        auto_on = 1'b1;
        k = 0;
        while (o_take_valid !== 1'b0 && k < 20) begin
            tick(1);
            k++;
        end
        auto_on = 1'b0;
        chk("boot_end", o_take_valid, 0);
        foreach (rows[r]) begin
            ln = rows[r][1];
            cmd_n.set_enable = 32'h1 << ln;
            go();
            src_v[rows[r][0]] = 1'b1;
            tick(2);
            chk("offer", o_take_excnum, 16 + ln);
            chk("vector", o_vector_addr, 4 * (16 + ln));
            chk("wake", o_wakeup, rows[r][2]);
            src_v = '0;
            model.ack_now();
            chk("active", o_active, 32'h1 << ln);
            chk("rank", o_exec_rank, 3);
            model.ret_now(6'd16 + ln[5:0]);
            chk("retired", o_active, 0);
            cmd_n.clr_enable = '1;
            go();
        end
        cmd_n.set_pending = '1;
        go();
        chk("pend_mask", o_pending, ~RESERVED_MASK);
        chk("no_offer", o_take_valid, 0);
        cmd_n.clr_pending = '1;
        go();
        chk("unpend", o_pending, 0);
        cmd_n.set_enable = 32'h1;
        cmd_n.set_pending = 32'h1;
        cmd_n.sys_set_pending = 3'h1;
        go();
        chk("tie_sys", o_take_excnum, 11);
        chk("sys_pend", o_sys_pending, 1);
        model.ack_now();
        chk("sys_act", {o_sys_active, o_sys_pending, o_take_valid}, 7'h10);
        model.ret_now(6'd11);
        chk("after_sys", o_take_excnum, 16);
        cmd_n = '{clr_pending: 32'h1, clr_enable: 32'h1, sys_clr_pending: 3'h1, default: '0};
        go();
        chk("tie_gone", o_take_valid, 0);
        cmd_n = '{sys_prio_wr_en: 1'b1, sys_prio_wr_data: 6'h3F, default: '0};
        go();
        chk("sys_prio", o_sys_prio, 32'h3F);
        cmd_n = '{prio_wr_en: 1'b1, prio_wr_idx: 3'h2, prio_wr_data: '1, default: '0};
        go();
        cmd_n = '{prio_wr_en: 1'b1, prio_wr_idx: 3'h0, prio_wr_data: 32'h7F, default: '0};
        go();
        rd_prio(3'h2, 32'hC0C0_C0C0);
        rd_prio(3'h0, 32'h0000_0040);
        cmd_n.set_enable = 32'h301;
        cmd_n.set_pending = 32'h300;
        go();
        chk("tie_line", o_take_excnum, 24);
        model.ack_now();
        chk("rank_l3", {o_exec_rank, o_take_valid}, 4'hC);
        cmd_n.set_pending = 32'h1;
        go();
        chk("preempt", o_take_excnum, 16);
        model.ack_now();
        chk("rank_l1", o_exec_rank, 4);
        cmd_n.clr_enable = 32'h100;
        cmd_n.clr_pending = 32'h101;
        go();
        chk("keep_act", o_active, 32'h101);
        model.ret_now(6'd16);
        tick(1);
        model.ret_now(6'd24);
        tick(1);
        chk("next_l3", o_take_excnum, 25);
        model.ack_now();
        model.ret_now(6'd25);
        i_nmi = 1'b1;
        tick(2);
        chk("nmi", {o_take_excnum, o_vector_addr[7:0]}, 14'h0208);
        model.ack_now();
        i_nmi = 1'b0;
        i_hard_fault = 1'b1;
        tick(2);
        chk("hf_wait", {o_exec_rank, o_take_valid}, 4'h2);
        model.ret_now(6'd2);
        tick(1);
        chk("hf", o_take_excnum, 3);
        model.ack_now();
        i_hard_fault = 1'b0;
        chk("hf_rank", o_exec_rank, 2);
        model.ret_now(6'd3);
        i_rstn = 1'b0;
        tick(2);
        i_rstn = 1'b1;
        tick(1);
        chk("reboot", {o_take_valid, o_take_excnum, o_enable}, 39'h40_0000_0000);
        rd_prio(3'h2, 32'h0);
        finish_test();
    end
endmodule : prioritized_vectored_irq_ctrl_bench
bind prioritized_vectored_irq_ctrl irq_ctrl_props props (
    .i_clk_sys, .i_rstn, .i_cmd, .i_take_ack, .i_exc_return, .o_take_valid,
    .o_take_excnum, .o_vector_addr, .o_enable, .o_pending, .o_active, .o_exec_rank);
`default_nettype wire

// >>> src/irq_ctrl_pkg.sv
// Purpose: Shared types and constants of the vectored interrupt controller
// Assumes: One core clock, all sources synchronous to it
// Notes:   Lines and exception numbers follow the fixed interrupt map
package irq_ctrl_pkg;

    localparam int unsigned NUM_IRQ       = 32;
    localparam int unsigned NUM_SYS       = 3;
    localparam int unsigned PRIO_PER_REG  = 4;
    localparam int unsigned PRIO_FIELD_W  = 8;
    localparam int unsigned PRIO_IMPL_LSB = 6;
    localparam int unsigned NUM_PRIO_REGS = 8;

    localparam logic [31:0] VECTOR_BASE    = 32'h0000_0000;
    localparam logic [5:0]  EXC_NONE       = 6'h00;
    localparam logic [5:0]  EXC_RESET      = 6'h01;
    localparam logic [5:0]  EXC_NMI        = 6'h02;
    localparam logic [5:0]  EXC_HARDFAULT  = 6'h03;
    localparam logic [5:0]  EXC_SUPERVISOR_CALL_EXCEPTION     = 6'h0B;
    localparam logic [5:0]  EXC_PENDABLE_SERVICE_EXCEPTION     = 6'h0E;
    localparam logic [5:0]  EXC_SYSTEM_TICK_EXCEPTION    = 6'h0F;
    localparam logic [5:0]  EXC_IRQ_BASE   = 6'h10;

    // Ranks: smaller is more urgent; reset has no rank, its boot fetches run first at rank 7
    localparam logic [2:0]  RANK_NMI       = 3'h1;
    localparam logic [2:0]  RANK_HARDFAULT = 3'h2;
    localparam logic [2:0]  RANK_CFG_BASE  = 3'h3;
    localparam logic [2:0]  RANK_THREAD    = 3'h7;
    localparam logic [1:0]  PRIO_RESET     = 2'h0;

    localparam logic [31:0] WAKE_MASK      = 32'h100F_103F;
    localparam logic [31:0] RESERVED_MASK  = 32'hCF00_A080;

    typedef enum logic [2:0] {
        ST_BOOT_SP = 3'b001,
        ST_BOOT_PC = 3'b010,
        ST_RUN     = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic        brownout_irq;
        logic        watchdog_irq;
        logic        ext_pin_irq_a;
        logic        ext_pin_irq_b;
        logic [15:0] port_group_a_irq;
        logic [21:0] port_group_b_irq;
        logic [3:0]  pwm_group_irq;
        logic        timer_zero_irq;
        logic        timer_one_irq;
        logic        timer_two_irq;
        logic        timer_three_irq;
        logic        serial_port_irq;
        logic        serial_periph_irq;
        logic [7:0]  port_group_c_irq;
        logic [9:0]  port_group_d_irq;
        logic        two_wire_a_irq;
        logic        two_wire_b_irq;
        logic        capture_ch0_irq;
        logic        capture_ch1_irq;
        logic        capture_ch2_irq;
        logic        capture_ch3_irq;
        logic        powerdown_wakeup_irq;
        logic        adc_irq;
    } irq_sources_t;

    typedef struct packed {
        logic [31:0] set_enable;
        logic [31:0] clr_enable;
        logic [31:0] set_pending;
        logic [31:0] clr_pending;
        logic        prio_wr_en;
        logic [2:0]  prio_wr_idx;
        logic [31:0] prio_wr_data;
        logic [2:0]  prio_rd_idx;
        logic        sys_prio_wr_en;
        logic [5:0]  sys_prio_wr_data;
        logic [2:0]  sys_set_pending;
        logic [2:0]  sys_clr_pending;
    } sw_cmd_t;

    typedef struct packed {
        seq_state_t       seq;
        logic [31:0]      enable;
        logic [31:0]      pending;
        logic [31:0]      active;
        logic [31:0][1:0] irq_prio;
        logic [2:0][1:0]  sys_prio;
        logic [2:0]       sys_pend;
        logic [2:0]       sys_act;
        logic             nmi_pend;
        logic             nmi_act;
        logic             hf_pend;
        logic             hf_act;
        logic             take_valid;
        logic [5:0]       take_excnum;
        logic [31:0]      vector_addr;
        logic [31:0]      prio_rd_data;
        logic [2:0]       exec_rank;
        logic             wakeup;
    } ctrl_state_t;

endpackage : irq_ctrl_pkg

// >>> src/prioritized_vectored_irq_ctrl.sv
// Purpose: Nested vectored interrupt controller with four priority levels
// Assumes: Sources, commands and core handshake are on i_clk_sys
// Notes:   Control and status bits are plain ports, no register bus
//
// Overview of operation
// - Four configurable levels; level 0 most urgent, level 3 least urgent.
// - Every configurable priority resets to level 0.
// - Reset, NMI and hard fault rank above every configurable level.
// - Lines 0 to 31 map to exception numbers 16 to 47.
// - Vector address is four times exception number; line 0 is brown-out.
// - Line 1 watchdog, lines 2 and 3 external pins; all wake.
// - Line 4 ports 0-1, line 5 ports 2-4; both wake.
// - Line 6 PWM, 8-11 timers, 12 UART, 14 SPI; UART wakes only.
// - Lines 16-17 port groups, 18-19 two-wire controllers; all wake.
// - Lines 20 to 23 are capture channels, none wake.
// - Line 28 power-down wake-up wakes, line 29 converter does not.
// - Vector table base fixed at zero.
// - Word 0 gives initial stack pointer; word n gives handler n.
// - Handler address supplied by hardware with the accepted exception.
// - Write-one set and clear of enable; both read current enable.
// - Asserted but disabled interrupt becomes pending, never active.
// - Disabling leaves an active interrupt active until return or reset.
// - Write-one set and clear of pending; both read current pending.
// - Clearing pending never alters active status.
// - Priorities sit in 8-bit fields, four per 32-bit word.
// - Higher priority pending request preempts the running handler.
// - Thirty-two lines with four priority levels.
`timescale 1ns/1ps
`default_nettype none

module prioritized_vectored_irq_ctrl (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rstn,
    input  wire irq_ctrl_pkg::irq_sources_t  i_sources,
    input  wire irq_ctrl_pkg::sw_cmd_t       i_cmd,
    input  wire logic                        i_nmi,
    input  wire logic                        i_hard_fault,
    input  wire logic                        i_take_ack,
    input  wire logic                        i_exc_return,
    input  wire logic [5:0]                  i_ret_excnum,
    output logic                             o_take_valid,
    output logic [5:0]                       o_take_excnum,
    output logic [31:0]                      o_vector_addr,
    output logic [31:0]                      o_enable,
    output logic [31:0]                      o_pending,
    output logic [31:0]                      o_active,
    output logic [31:0]                      o_prio_rd_data,
    output logic [5:0]                       o_sys_prio,
    output logic [2:0]                       o_sys_pending,
    output logic [2:0]                       o_sys_active,
    output logic [2:0]                       o_exec_rank,
    output logic                             o_wakeup
);
    import irq_ctrl_pkg::*;

    // ************************************************************
    // Helper functions
    // ************************************************************
    function automatic logic [31:0] map_lines(input irq_sources_t s);
        logic [31:0] l;
        l     = '0;
        l[0]  = s.brownout_irq;
        l[1]  = s.watchdog_irq;
        l[2]  = s.ext_pin_irq_a;
        l[3]  = s.ext_pin_irq_b;
        l[4]  = |s.port_group_a_irq;
        l[5]  = |s.port_group_b_irq;
        l[6]  = |s.pwm_group_irq;
        l[8]  = s.timer_zero_irq;
        l[9]  = s.timer_one_irq;
        l[10] = s.timer_two_irq;
        l[11] = s.timer_three_irq;
        l[12] = s.serial_port_irq;
        l[14] = s.serial_periph_irq;
        l[16] = |s.port_group_c_irq;
        l[17] = |s.port_group_d_irq;
        l[18] = s.two_wire_a_irq;
        l[19] = s.two_wire_b_irq;
        l[20] = s.capture_ch0_irq;
        l[21] = s.capture_ch1_irq;
        l[22] = s.capture_ch2_irq;
        l[23] = s.capture_ch3_irq;
        l[28] = s.powerdown_wakeup_irq;
        l[29] = s.adc_irq;
        return l;
    endfunction : map_lines

    function automatic logic [47:0] exc_onehot(input logic [5:0] exc);
        return 48'h0000_0000_0001 << exc;
    endfunction : exc_onehot

    function automatic logic [31:0] vec_addr(input logic [5:0] exc);
        return VECTOR_BASE + {24'h00_0000, exc, 2'b00};
    endfunction : vec_addr

    function automatic logic [2:0] cfg_rank(input logic [1:0] lvl);
        return RANK_CFG_BASE + {1'b0, lvl};
    endfunction : cfg_rank

    // ************************************************************
    // State
    // ************************************************************
    ctrl_state_t q;
    ctrl_state_t d;

    logic [31:0] lines;
    logic [47:0] ack_oh;
    logic [47:0] ret_oh;
    logic        ack_run;
    logic [31:0] ack_irq;
    logic [2:0]  ack_sys;
    logic [31:0] ret_irq;
    logic [2:0]  ret_sys;
    logic [2:0]  best_rank;
    logic [5:0]  best_exc;
    logic        found;
    logic [1:0]  lvl;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d         = q;
        lines     = map_lines(i_sources);
        ack_run   = q.take_valid && i_take_ack && (q.seq == ST_RUN);
        ack_oh    = ack_run ? exc_onehot(q.take_excnum) : '0;
        ret_oh    = i_exc_return ? exc_onehot(i_ret_excnum) : '0;
        ack_irq   = ack_oh[47:16];
        ack_sys   = {ack_oh[15], ack_oh[14], ack_oh[11]};
        ret_irq   = ret_oh[47:16];
        ret_sys   = {ret_oh[15], ret_oh[14], ret_oh[11]};
        best_rank = RANK_THREAD;
        best_exc  = EXC_NONE;
        found     = 1'b0;
        lvl       = PRIO_RESET;

        // Enable bits
        d.enable = ((q.enable & ~i_cmd.clr_enable) | i_cmd.set_enable)
                   & ~RESERVED_MASK;

        // Pending: hardware and software set win over clear
        d.pending = ((q.pending & ~i_cmd.clr_pending & ~ack_irq)
                     | i_cmd.set_pending
                     | (lines & ~q.active & ~ack_irq))
                    & ~RESERVED_MASK;

        // Active: only acceptance and return change it
        d.active = (q.active & ~ret_irq) | ack_irq;

        d.sys_pend = (q.sys_pend & ~i_cmd.sys_clr_pending & ~ack_sys)
                     | i_cmd.sys_set_pending;
        d.sys_act  = (q.sys_act & ~ret_sys) | ack_sys;
        d.nmi_pend = (q.nmi_pend & ~ack_oh[2]) | (i_nmi & ~q.nmi_act & ~ack_oh[2]);
        d.nmi_act  = (q.nmi_act & ~ret_oh[2]) | ack_oh[2];
        d.hf_pend  = (q.hf_pend & ~ack_oh[3])
                     | (i_hard_fault & ~q.hf_act & ~ack_oh[3]);
        d.hf_act   = (q.hf_act & ~ret_oh[3]) | ack_oh[3];

        // Priority fields: top two bits of each byte for lines, whole 6-bit word for system
        if (i_cmd.prio_wr_en) begin
            for (int b = 0; b < PRIO_PER_REG; b++) begin
                d.irq_prio[int'(i_cmd.prio_wr_idx) * PRIO_PER_REG + b] =
                    i_cmd.prio_wr_data[b * PRIO_FIELD_W + PRIO_IMPL_LSB +: 2];
            end
        end
        if (i_cmd.sys_prio_wr_en) begin
            d.sys_prio = i_cmd.sys_prio_wr_data;
        end

        // Priority read word
        for (int b = 0; b < PRIO_PER_REG; b++) begin
            d.prio_rd_data[b * PRIO_FIELD_W +: PRIO_FIELD_W] =
                {q.irq_prio[int'(i_cmd.prio_rd_idx) * PRIO_PER_REG + b], 6'h00};
        end

        // Current execution rank from everything active
        d.exec_rank = RANK_THREAD;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (d.active[i] && cfg_rank(d.irq_prio[i]) < d.exec_rank) begin
                d.exec_rank = cfg_rank(d.irq_prio[i]);
            end
        end
        for (int i = 0; i < NUM_SYS; i++) begin
            if (d.sys_act[i] && cfg_rank(d.sys_prio[i]) < d.exec_rank) begin
                d.exec_rank = cfg_rank(d.sys_prio[i]);
            end
        end
        if (d.hf_act) begin
            d.exec_rank = RANK_HARDFAULT;
        end
        if (d.nmi_act) begin
            d.exec_rank = RANK_NMI;
        end

        // Arbitration: strict improvement keeps the lowest number on ties
        best_rank = d.exec_rank;
        if (d.nmi_pend && RANK_NMI < best_rank) begin
            best_rank = RANK_NMI;
            best_exc  = EXC_NMI;
            found     = 1'b1;
        end
        if (d.hf_pend && RANK_HARDFAULT < best_rank) begin
            best_rank = RANK_HARDFAULT;
            best_exc  = EXC_HARDFAULT;
            found     = 1'b1;
        end
        for (int i = 0; i < NUM_SYS; i++) begin
            lvl = d.sys_prio[i];
            if (d.sys_pend[i] && cfg_rank(lvl) < best_rank) begin
                best_rank = cfg_rank(lvl);
                best_exc  = (i == 0) ? EXC_SUPERVISOR_CALL_EXCEPTION : ((i == 1) ? EXC_PENDABLE_SERVICE_EXCEPTION : EXC_SYSTEM_TICK_EXCEPTION);
                found     = 1'b1;
            end
        end
        for (int i = 0; i < NUM_IRQ; i++) begin
            lvl = d.irq_prio[i];
            if (d.pending[i] && d.enable[i] && cfg_rank(lvl) < best_rank) begin
                best_rank = cfg_rank(lvl);
                best_exc  = EXC_IRQ_BASE + 6'(i);
                found     = 1'b1;
            end
        end

        // Vector fetch sequence
        case (q.seq)
            ST_BOOT_SP: begin
                if (i_take_ack) begin
                    d.seq         = ST_BOOT_PC;
                    d.take_excnum = EXC_RESET;
                    d.vector_addr = vec_addr(EXC_RESET);
                end
            end
            ST_BOOT_PC: begin
                if (i_take_ack) begin
                    d.seq        = ST_RUN;
                    d.take_valid = 1'b0;
                end
            end
            ST_RUN: begin
                d.take_valid  = found;
                d.take_excnum = found ? best_exc : EXC_NONE;
                d.vector_addr = found ? vec_addr(best_exc) : VECTOR_BASE;
            end
            default: begin
                d.seq = ST_BOOT_SP;
            end
        endcase

        d.wakeup = |(d.pending & d.enable & WAKE_MASK);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            q             <= '0;
            q.seq         <= ST_BOOT_SP;
            q.take_valid  <= 1'b1;
            q.exec_rank   <= RANK_THREAD;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_take_valid   = q.take_valid;
    assign o_take_excnum  = q.take_excnum;
    assign o_vector_addr  = q.vector_addr;
    assign o_enable       = q.enable;
    assign o_pending      = q.pending;
    assign o_active       = q.active;
    assign o_prio_rd_data = q.prio_rd_data;
    assign o_sys_prio     = q.sys_prio;
    assign o_sys_pending  = q.sys_pend;
    assign o_sys_active   = q.sys_act;
    assign o_exec_rank    = q.exec_rank;
    assign o_wakeup       = q.wakeup;

endmodule : prioritized_vectored_irq_ctrl

`default_nettype wire
